/* rtl/hbpg_regs.svh */
/*
 * timing, field and mode constants for the half-bridge pwm generator.
 * assumes a 100 mhz system clock; included by bare name.
 */
`ifndef HBPG_REGS_SVH
`define HBPG_REGS_SVH

`define HBPG_CLK_HZ          100000000
`define HBPG_CLK_PERIOD_NS   10
`define HBPG_FREQ_STEP_HZ    5000
`define HBPG_DT_STEP_NS      400
`define HBPG_DT_STEP_CYC     ((`HBPG_DT_STEP_NS + `HBPG_CLK_PERIOD_NS - 1) \
                              / `HBPG_CLK_PERIOD_NS)
`define HBPG_SW_W            6
`define HBPG_FSEL_LSB        0
`define HBPG_DSEL_LSB        3
`define HBPG_SEL_W           3
`define HBPG_SW_ALL_ON       6'h3f
`define HBPG_DUTY_CAP_SHIFT  6
`define HBPG_DEAD_W          9

`endif

/* rtl/hbpg_pkg.sv */
/*
 * types for the half-bridge pwm generator.
 * assumes nothing beyond the constants header.
 */
package hbpg_pkg;

    typedef enum logic [1:0] {
        HBPG_STOPPED = 2'h0,
        HBPG_RUNNING = 2'h1,
        HBPG_SLEEP   = 2'h2
    } hbpg_mode_t;

endpackage : hbpg_pkg

/* rtl/hbpg_edge_if.sv */
/*
 * link between the pwm core and one dead-time delay channel.
 * assumes both ends share sys_clk.
 */
`timescale 1ns/100ps
`include "hbpg_regs.svh"

interface hbpg_edge_if;
    logic                      raw;
    logic [`HBPG_DEAD_W-1:0]   dead_cyc;
    logic                      gated;

    modport gen (output raw, output dead_cyc, input  gated);
    modport dly (input  raw, input  dead_cyc, output gated);
endinterface : hbpg_edge_if

/* rtl/hbpg_dead_edge.sv */
/*
 * one dead-time channel: holds off the rising edge of a drive pulse
 * by dead_cyc cycles; falling edges pass at once.
 * assumes raw and dead_cyc are on sys_clk.
 */
`timescale 1ns/100ps
`include "hbpg_regs.svh"

module hbpg_dead_edge (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // channel
    hbpg_edge_if.dly  ch
);

    logic [`HBPG_DEAD_W-1:0] age_r;
    logic [`HBPG_DEAD_W-1:0] age_nxt;

    always_comb begin
        if (!ch.raw) begin
            age_nxt = '0;
        end else if (age_r >= ch.dead_cyc) begin
            age_nxt = age_r;
        end else begin
            age_nxt = age_r + `HBPG_DEAD_W'(1);
        end
        // dead time eaten from the leading edge only
        ch.gated = ch.raw && (age_r >= ch.dead_cyc);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            age_r <= '0;
        end else begin
            age_r <= age_nxt;
        end
    end

endmodule : hbpg_dead_edge

/* rtl/hbpg_top.sv */
/*
 * half-bridge pwm generator with dead time, switch-bank setup, a duty
 * knob and external pass-through.
 * assumes button, switch, knob and external inputs are asynchronous
 * and already debounced; the knob is an adc code of the tap voltage.
 */
// Notes on behaviour
// - frequency selectable 5 khz to 40 khz in eight 5 khz steps.
// - dead time 0 to 2.8 us in 400 ns steps, zero allowed.
// - switches 0..2 pick frequency, switches 3..5 pick dead time.
// - all six switches on routes external drive inputs to outputs.
// - frequency and dead-time settings are latched only when generation starts.
// - switch changes while running, except all six on, wait for stop then restart.
// - duty follows knob code linearly, independent of frequency.
// - duty spans 0 percent up to about 98 percent of period.
// - dead time is cut from each pulse's leading edge.
// - each start/stop press outside sleep toggles running and stopped; a sleep press in the same cycle wins and enters sleep.
// - sleep press toggles sleep; reset restarts from initial state.
`timescale 1ns/100ps
`include "hbpg_regs.svh"

module hbpg_top #(
    parameter int CLK_HZ  = `HBPG_CLK_HZ,
    parameter int STEP_HZ = `HBPG_FREQ_STEP_HZ,
    parameter int KNOB_W  = 8,
    parameter int PER_W   = 15
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // push buttons, high while pressed
    input  wire logic                   start_stop_btn,
    input  wire logic                   sleep_btn,
    // setup switches and duty knob
    input  wire logic [`HBPG_SW_W-1:0]  timing_select_switch,
    input  wire logic [KNOB_W-1:0]      duty_knob,
    // external drive in
    input  wire logic                   ext_high_drive,
    input  wire logic                   ext_low_drive,
    // gate driver inputs
    output logic                        high_side_drive_in,
    output logic                        low_side_drive_in,
    // status
    output logic                        running,
    output logic                        sleep_mode,
    output logic                        external_mode
);

    localparam int SYN_W = 2 + `HBPG_SW_W + KNOB_W + 2;

    // two-flop synchroniser; s3 only feeds the press edge detectors
    logic [SYN_W-1:0] s1_r, s2_r;
    logic [1:0]       s3_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {start_stop_btn, sleep_btn, timing_select_switch,
                     duty_knob, ext_high_drive, ext_low_drive};
            s2_r <= s1_r;
            s3_r <= s2_r[SYN_W-1 -: 2];
        end
    end

    logic                  start_s, sleep_s, ext_hi_s, ext_lo_s;
    logic [`HBPG_SW_W-1:0] sw_s;
    logic [KNOB_W-1:0]     knob_s;
    logic                  start_press, sleep_press, sw_all_on;

    assign {start_s, sleep_s, sw_s, knob_s, ext_hi_s, ext_lo_s} = s2_r;
    assign start_press = start_s && !s3_r[1];
    assign sleep_press = sleep_s && !s3_r[0];
    assign sw_all_on   = (sw_s == `HBPG_SW_ALL_ON);

    function automatic logic [PER_W-1:0] period_of(
        input logic [`HBPG_SEL_W-1:0] code
    );
        // code k gives (k+1) * step frequency
        case (code)
            3'h0:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 1));
            3'h1:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 2));
            3'h2:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 3));
            3'h3:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 4));
            3'h4:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 5));
            3'h5:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 6));
            3'h6:    period_of = PER_W'(CLK_HZ / (STEP_HZ * 7));
            default: period_of = PER_W'(CLK_HZ / (STEP_HZ * 8));
        endcase
    endfunction : period_of

    // mode and latched setup
    hbpg_pkg::hbpg_mode_t          mode_r, mode_nxt;
    logic [`HBPG_SEL_W-1:0]        fsel_r, fsel_nxt;
    logic [`HBPG_SEL_W-1:0]        dsel_r, dsel_nxt;
    logic                          start_now;

    always_comb begin
        mode_nxt  = mode_r;
        fsel_nxt  = fsel_r;
        dsel_nxt  = dsel_r;
        start_now = 1'b0;
        case (mode_r)
            hbpg_pkg::HBPG_STOPPED: begin
                if (sleep_press) begin
                    mode_nxt = hbpg_pkg::HBPG_SLEEP;
                end else if (start_press) begin
                    mode_nxt  = hbpg_pkg::HBPG_RUNNING;
                    start_now = 1'b1;
                    // setup is taken here and nowhere else
                    fsel_nxt = sw_s[`HBPG_FSEL_LSB +: `HBPG_SEL_W];
                    dsel_nxt = sw_s[`HBPG_DSEL_LSB +: `HBPG_SEL_W];
                end
            end
            hbpg_pkg::HBPG_RUNNING: begin
                if (sleep_press) begin
                    mode_nxt = hbpg_pkg::HBPG_SLEEP;
                end else if (start_press) begin
                    mode_nxt = hbpg_pkg::HBPG_STOPPED;
                end
            end
            hbpg_pkg::HBPG_SLEEP: begin
                // wake to stopped so a stale setup never restarts silently
                if (sleep_press) begin
                    mode_nxt = hbpg_pkg::HBPG_STOPPED;
                end
            end
            default: mode_nxt = hbpg_pkg::HBPG_STOPPED;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_r <= hbpg_pkg::HBPG_STOPPED;
            fsel_r <= '0;
            dsel_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            fsel_r <= fsel_nxt;
            dsel_r <= dsel_nxt;
        end
    end

    // period counter and duty compare
    logic                         gen_on;
    logic [PER_W-1:0]             period, cnt_r, cnt_nxt, on_r, on_nxt;
    logic [PER_W-1:0]             period_ld;
    logic [PER_W+KNOB_W-1:0]      prod;
    logic [PER_W-1:0]             on_knob, on_cap;
    logic                         wrap;

    assign gen_on = (mode_r == hbpg_pkg::HBPG_RUNNING) && !sw_all_on;
    assign period = period_of(fsel_r);
    // duty is sized against the period about to run, so the first
    // period after start already uses the freshly latched code
    assign period_ld = period_of(fsel_nxt);

    always_comb begin
        prod    = (PER_W+KNOB_W)'(period_ld) * (PER_W+KNOB_W)'(knob_s);
        on_knob = prod[PER_W+KNOB_W-1:KNOB_W];
        on_cap  = period_ld - (period_ld >> `HBPG_DUTY_CAP_SHIFT);
        wrap    = (cnt_r >= period - PER_W'(1));
        cnt_nxt = (!gen_on || start_now || wrap) ? '0
                                                 : cnt_r + PER_W'(1);
        // while generating, duty moves only at a period boundary to avoid runt pulses
        on_nxt  = on_r;
        if (!gen_on || wrap) begin
            on_nxt = (on_knob > on_cap) ? on_cap : on_knob;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            on_r  <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            on_r  <= on_nxt;
        end
    end

    // dead-time channels; zero dead time relies on external delay
    hbpg_edge_if hi_ch ();
    hbpg_edge_if lo_ch ();

    assign hi_ch.raw      = gen_on && (cnt_r < on_r);
    assign lo_ch.raw      = gen_on && !(cnt_r < on_r);
    assign hi_ch.dead_cyc = `HBPG_DEAD_W'(dsel_r)
                          * `HBPG_DEAD_W'(`HBPG_DT_STEP_CYC);
    assign lo_ch.dead_cyc = hi_ch.dead_cyc;

    hbpg_dead_edge u_hi_dead (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ch      (hi_ch.dly)
    );

    hbpg_dead_edge u_lo_dead (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ch      (lo_ch.dly)
    );

    // output stage
    logic hi_r, hi_nxt, lo_r, lo_nxt;

    always_comb begin
        if (sw_all_on) begin
            hi_nxt = ext_hi_s;
            lo_nxt = ext_lo_s;
        end else begin
            // belt and braces: the two can never be driven together
            hi_nxt = hi_ch.gated && !lo_ch.gated;
            lo_nxt = lo_ch.gated && !hi_ch.gated;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    assign high_side_drive_in = hi_r;
    assign low_side_drive_in  = lo_r;
    assign running            = (mode_r == hbpg_pkg::HBPG_RUNNING);
    assign sleep_mode         = (mode_r == hbpg_pkg::HBPG_SLEEP);
    assign external_mode      = sw_all_on;

endmodule : hbpg_top

/* verif/hbpg_gate_model.sv */
/* gate driver input model: counts on-cycles of each drive, flags overlap.
   assumes drives settle on sys_clk. */
`timescale 1ns/100ps
module hbpg_gate_model (
    // clock and clear
    input  wire logic        sys_clk,
    input  wire logic        clr,
    // driver inputs
    input  wire logic        high_side_drive_in,
    input  wire logic        low_side_drive_in,
    // observations
    output logic      [31:0] hi_cyc,
    output logic      [31:0] lo_cyc,
    output logic             overlap
);
    // both gates on shorts the bridge; latched so no glitch is lost
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            hi_cyc  <= '0;
            lo_cyc  <= '0;
            overlap <= 1'b0;
        end else begin
            hi_cyc  <= hi_cyc + {31'h0, high_side_drive_in};
            lo_cyc  <= lo_cyc + {31'h0, low_side_drive_in};
            overlap <= overlap
                       | (high_side_drive_in & low_side_drive_in);
        end
    end
endmodule : hbpg_gate_model

/* verif/hbpg_properties.sv */
/* pin-level assertions for the pwm generator.
   bound into hbpg_top; single clock domain. */
`timescale 1ns/100ps
module hbpg_props #(
    parameter int CLK_HZ  = 100000000,
    parameter int STEP_HZ = 5000,
    parameter int KNOB_W  = 8
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              reset,
    // controls
    input wire logic              start_stop_btn,
    input wire logic              sleep_btn,
    input wire logic [5:0]        timing_select_switch,
    input wire logic [KNOB_W-1:0] duty_knob,
    input wire logic              ext_high_drive,
    input wire logic              ext_low_drive,
    // results
    input wire logic              high_side_drive_in,
    input wire logic              low_side_drive_in,
    input wire logic              running,
    input wire logic              sleep_mode,
    input wire logic              external_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // two longest periods plus 300 cycles, more than the full dead time
    localparam int ZERO_CYC = 2 * CLK_HZ / STEP_HZ + 300;
    logic [31:0] idle_r, idle_nxt, quiet_r, quiet_nxt, zero_r, zero_nxt;
    always_comb begin
        idle_nxt  = (running | external_mode) ? '0 : idle_r + 1;
        quiet_nxt = (start_stop_btn | sleep_btn) ? '0 : quiet_r + 1;
        zero_nxt  = (running & ~external_mode & duty_knob == '0) ?
                    zero_r + 1 : '0;
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            idle_r  <= '0;
            quiet_r <= '0;
            zero_r  <= '0;
        end else begin
            idle_r  <= idle_nxt;
            quiet_r <= quiet_nxt;
            zero_r  <= zero_nxt;
        end
    end
    chk_never_both: assert property (
        !external_mode && !$past(external_mode) |->
        !(high_side_drive_in && low_side_drive_in)) else $error("both on");
    chk_ext_pass: assert property (
        external_mode && $past(external_mode) |->
        high_side_drive_in == $past(ext_high_drive, 3) &&
        low_side_drive_in == $past(ext_low_drive, 3)) else $error("ext pass");
    chk_ext_flag: assert property (
        !$past(reset) && !$past(reset, 2) |-> external_mode ==
        ($past(timing_select_switch, 2) == 6'h3f)) else $error("ext flag");
    chk_start_run: assert property (
        $rose(start_stop_btn) && !sleep_btn && !running && !sleep_mode
        |-> ##[3:5] running) else $error("no start");
    chk_sleep_enter: assert property (
        $rose(sleep_btn) && !sleep_mode |-> ##[3:5] sleep_mode && !running)
        else $error("no sleep");
    chk_quiet_mode: assert property (
        quiet_r > 32'h0000_0005 |-> $stable(running) && $stable(sleep_mode))
        else $error("mode moved");
    chk_idle_low: assert property (
        idle_r > 32'h0000_0004 |-> !high_side_drive_in && !low_side_drive_in)
        else $error("idle drive");
    chk_knob_zero: assert property (
        zero_r >= ZERO_CYC |-> !high_side_drive_in) else $error("zero duty");
endmodule : hbpg_props

bind hbpg_top hbpg_props #(
    .CLK_HZ(CLK_HZ), .STEP_HZ(STEP_HZ), .KNOB_W(KNOB_W)
) chk_u (
    .sys_clk(sys_clk), .reset(reset), .start_stop_btn(start_stop_btn),
    .sleep_btn(sleep_btn), .timing_select_switch(timing_select_switch),
    .duty_knob(duty_knob), .ext_high_drive(ext_high_drive),
    .ext_low_drive(ext_low_drive), .high_side_drive_in(high_side_drive_in),
    .low_side_drive_in(low_side_drive_in), .running(running),
    .sleep_mode(sleep_mode), .external_mode(external_mode)
);

/* verif/testbench.sv */
/* self-checking bench for hbpg_top and the gate driver model.
   assumes 100 mhz; periods shortened by a larger frequency step. */
`timescale 1ns/100ps
module testbench;
    localparam int CLK = 100000000;
    localparam int STEP = 100000;
    typedef struct {int f; int d; int k; int hi; int lo;} hbpg_row_t;
    logic sys_clk = 0, reset = 1, start_stop_btn = 0, sleep_btn = 0;
    logic clr = 0, ext_high_drive = 0, ext_low_drive = 0;
    logic [5:0] timing_select_switch = '0;
    logic [7:0] duty_knob = '0;
    logic high_side_drive_in, low_side_drive_in, running, sleep_mode;
    logic external_mode, overlap;
    logic [31:0] hi_cyc, lo_cyc;
    logic [1:0] drv;
    assign drv = {high_side_drive_in, low_side_drive_in};
    int n_mismatch = 0, n_tests = 0;
    hbpg_row_t rows [8];
    always #5 sys_clk = ~sys_clk;
    hbpg_top #(.STEP_HZ(STEP)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .start_stop_btn(start_stop_btn),
        .sleep_btn(sleep_btn), .timing_select_switch(timing_select_switch),
        .duty_knob(duty_knob), .ext_high_drive(ext_high_drive),
        .ext_low_drive(ext_low_drive), .high_side_drive_in(high_side_drive_in),
        .low_side_drive_in(low_side_drive_in), .running(running),
        .sleep_mode(sleep_mode), .external_mode(external_mode));
    hbpg_gate_model model_u (
        .sys_clk(sys_clk), .clr(clr), .high_side_drive_in(high_side_drive_in),
        .low_side_drive_in(low_side_drive_in), .hi_cyc(hi_cyc),
        .lo_cyc(lo_cyc), .overlap(overlap));
    task automatic check(input string w, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", w, e, s);
        end
    endtask : check
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic press(input bit slp);
        if (slp) sleep_btn = 1;
        else start_stop_btn = 1;
        tick(2);
        sleep_btn = 0;
        start_stop_btn = 0;
        tick(6);
    endtask : press
    function automatic hbpg_row_t mk(input int f, d, k);
        int p, on, dt, lo;
        p = CLK / (STEP * (f + 1));
        on = (p * k) >> 8;
        if (on > p - (p >> 6)) on = p - (p >> 6);
        dt = d * 40;
        // a low side that never falls has no leading edge to trim
        lo = (on == 0) ? p : (p - on > dt ? p - on - dt : 0);
        mk = '{f, d, k, on > dt ? on - dt : 0, lo};
    endfunction : mk
    task automatic run_row(input hbpg_row_t r);
        int p;
        p = CLK / (STEP * (r.f + 1));
        timing_select_switch = {r.d[2:0], r.f[2:0]};
        duty_knob = r.k[7:0];
        press(0);
        check("running", running, 1);
        timing_select_switch = 6'h00; // ignored until restart
        tick(4 * p);
        clr = 1;
        tick(1);
        clr = 0;
        tick(4 * p);
        check("high cycles", hi_cyc, 4 * r.hi);
        check("low cycles", lo_cyc, 4 * r.lo);
        check("overlap", overlap, 0);
        press(0);
        check("stopped", running, 0);
        check("idle", drv, 0);
    endtask : run_row
    initial begin
        #500_000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        rows = '{mk(0, 7, 128), mk(1, 0, 255), mk(2, 1, 0), mk(3, 2, 64),
                 mk(4, 3, 200), mk(5, 4, 100), mk(6, 5, 255), mk(7, 6, 30)};
        tick(3);
        reset = 0;
        check("reset run", running, 0);
        foreach (rows[i]) run_row(rows[i]);
        press(1);
        check("sleep on", sleep_mode, 1);
        press(0);
        check("start in sleep", running, 0);
        press(1);
        check("sleep off", sleep_mode, 0);
        press(0);
        press(1);
        check("run to sleep", {running, sleep_mode}, 1);
        press(1);
        check("wake stopped", {running, sleep_mode}, 0);
        timing_select_switch = 6'h3f;
        for (int i = 0; i < 4; i++) begin
            {ext_high_drive, ext_low_drive} = i[1:0];
            tick(4);
            check("ext mode", external_mode, 1);
            check("ext drive", drv, i);
        end
        timing_select_switch = 6'h09;
        duty_knob = 8'h80;
        press(0);
        tick(50);
        reset = 1;
        tick(2);
        check("reset mid", {running, drv}, 0);
        reset = 0;
        press(0);
        check("restart", running, 1);
        end_sim();
    end
endmodule : testbench
